// [rtl/frt_timer.sv]
// Free-running 16-bit timer with two input captures and an APB slave
`timescale 1ns/10ps
`default_nettype none
module frt_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_mode,
  input wire logic global_irq_mask,
  input wire logic ext_clock_pin,
  input wire logic capture_pin_one,
  input wire logic capture_pin_two,
  output logic overflow_irq,
  output logic capture_irq
);
  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [15:0] count;
    logic [2:0] prescale;
    logic [7:0] low_latch;
    logic low_held;
    logic ovf_flag;
    logic ovf_armed;
    logic ext_last;
    logic [1:0] ext_sync;
    logic [1:0] cap1_sync;
    logic [1:0] cap2_sync;
    logic [31:0] rdata;
    logic rd_wait;
  } frt_state_t;

  frt_state_t st;
  frt_state_t next_st;

  logic access;
  logic rd;
  logic wr;
  logic mapped;
  logic [1:0] clock_select_bits;
  logic tick;
  logic ext_edge;
  logic [2:0] div_mask;
  logic special_mode;
  logic status_read;
  logic [15:0] cap1_value;
  logic [15:0] cap2_value;
  logic cap1_flag;
  logic cap2_flag;
  logic [7:0] status_byte;
  logic [7:0] read_byte;
  logic [31:0] read_word;

  assign access = psel && penable;
  // Reads take effect on the first access edge; the data register answers one cycle later
  assign rd = access && !pwrite && !st.rd_wait;
  assign wr = access && pwrite;
  assign clock_select_bits = {st.ctrl_two[frt_pkg::CR2_CLK_HI], st.ctrl_two[frt_pkg::CR2_CLK_LO]};
  assign special_mode = st.ctrl_two[frt_pkg::CR2_OPM] || st.ctrl_two[frt_pkg::CR2_PWM];
  assign status_read = rd && (paddr == frt_pkg::OFF_STATUS);
  assign status_byte = {cap1_flag, 1'b0, st.ovf_flag, cap2_flag, 4'h0};

  always_comb begin
    unique case (clock_select_bits)
      frt_pkg::CLK_DIV2: div_mask = frt_pkg::DIV2_MASK;
      frt_pkg::CLK_DIV4: div_mask = frt_pkg::DIV4_MASK;
      frt_pkg::CLK_DIV8: div_mask = frt_pkg::DIV8_MASK;
      frt_pkg::CLK_EXT: div_mask = frt_pkg::DIV8_MASK;
    endcase
  end

  // Edge found on the synchronised pin; the pin must be slow enough to be seen
  assign ext_edge = st.ctrl_two[frt_pkg::CR2_EXT_EDGE] ? (st.ext_sync[1] && !st.ext_last)
                                                      : (!st.ext_sync[1] && st.ext_last);

  always_comb begin
    if (clock_select_bits == frt_pkg::CLK_EXT) begin
      tick = ext_edge;
    end else begin
      tick = ((st.prescale & div_mask) == div_mask);
    end
  end

  always_comb begin
    mapped = 1'b1;
    read_byte = 8'h00;
    unique case (paddr)
      frt_pkg::OFF_CTRL_ONE: read_byte = st.ctrl_one;
      frt_pkg::OFF_CTRL_TWO: read_byte = st.ctrl_two;
      frt_pkg::OFF_STATUS: read_byte = status_byte;
      frt_pkg::OFF_CAP1_HI: read_byte = cap1_value[15:8];
      frt_pkg::OFF_CAP1_LO: read_byte = cap1_value[7:0];
      frt_pkg::OFF_CAP2_HI: read_byte = cap2_value[15:8];
      frt_pkg::OFF_CAP2_LO: read_byte = cap2_value[7:0];
      frt_pkg::OFF_CNT_HI, frt_pkg::OFF_ALT_HI: read_byte = st.count[15:8];
      frt_pkg::OFF_CNT_LO, frt_pkg::OFF_ALT_LO: begin
        // Held byte while a sequence is open, live byte otherwise
        read_byte = st.low_held ? st.low_latch : st.count[7:0];
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign read_word = {24'h000000, read_byte};

  always_comb begin
    next_st = st;
    next_st.ext_sync = {st.ext_sync[0], ext_clock_pin};
    next_st.ext_last = st.ext_sync[1];
    next_st.cap1_sync = {st.cap1_sync[0], capture_pin_one};
    next_st.cap2_sync = {st.cap2_sync[0], capture_pin_two};
    next_st.rd_wait = rd;
    if (!halt_mode) begin
      // Halt freezes counting; wait mode is not seen here at all
      next_st.prescale = st.prescale + 3'h1;
      if (tick) begin
        next_st.count = st.count + 16'h0001;
      end
    end
    if (rd) begin
      next_st.rdata = read_word;
      if (paddr == frt_pkg::OFF_CNT_HI || paddr == frt_pkg::OFF_ALT_HI) begin
        if (!st.low_held) begin
          next_st.low_latch = st.count[7:0];
        end
        next_st.low_held = 1'b1;
      end
      if (paddr == frt_pkg::OFF_CNT_LO || paddr == frt_pkg::OFF_ALT_LO) begin
        next_st.low_held = 1'b0;
      end
    end
    if (wr) begin
      unique case (paddr)
        frt_pkg::OFF_CTRL_ONE: next_st.ctrl_one = pwdata[7:0];
        frt_pkg::OFF_CTRL_TWO: next_st.ctrl_two = pwdata[7:0];
        frt_pkg::OFF_CNT_LO, frt_pkg::OFF_ALT_LO: begin
          next_st.count = frt_pkg::CNT_RESET;
          next_st.prescale = 3'h0;
        end
        default: begin
        end
      endcase
    end
    if (status_read && st.ovf_flag) begin
      next_st.ovf_armed = 1'b1;
    end
    // Only the main low byte completes the clear
    if (access && paddr == frt_pkg::OFF_CNT_LO && st.ovf_armed) begin
      next_st.ovf_flag = 1'b0;
      next_st.ovf_armed = 1'b0;
    end
    // Wrap sets the flag and wins over a simultaneous clear by read; a write to either low byte in that cycle stops the wrap
    if (!halt_mode && tick && st.count == 16'hFFFF
        && !(wr && (paddr == frt_pkg::OFF_CNT_LO || paddr == frt_pkg::OFF_ALT_LO))) begin
      next_st.ovf_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.count <= frt_pkg::CNT_RESET;
      st.ctrl_one <= frt_pkg::CR1_RESET;
      st.ctrl_two <= frt_pkg::CR2_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  frt_capture_chan u_cap1 (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_sync(st.cap1_sync[1]),
    .edge_rising(st.ctrl_one[frt_pkg::CR1_EDGE1]),
    .enable(!special_mode),
    .count(st.count),
    .status_read(status_read),
    .high_read(rd && paddr == frt_pkg::OFF_CAP1_HI),
    .low_access(access && paddr == frt_pkg::OFF_CAP1_LO),
    .low_read(rd && paddr == frt_pkg::OFF_CAP1_LO),
    .capture_register(cap1_value),
    .capture_flag(cap1_flag),
    .capture_event()
  );

  frt_capture_chan u_cap2 (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_sync(st.cap2_sync[1]),
    .edge_rising(st.ctrl_two[frt_pkg::CR2_EDGE2]),
    .enable(1'b1),
    .count(st.count),
    .status_read(status_read),
    .high_read(rd && paddr == frt_pkg::OFF_CAP2_HI),
    .low_access(access && paddr == frt_pkg::OFF_CAP2_LO),
    .low_read(rd && paddr == frt_pkg::OFF_CAP2_LO),
    .capture_register(cap2_value),
    .capture_flag(cap2_flag),
    .capture_event()
  );

  assign prdata = st.rdata;
  // Writes finish in one access cycle, reads insert one wait state
  assign pready = !(access && !pwrite) || st.rd_wait;
  assign pslverr = access && !mapped;
  // Requests stay pending in the flags until enable and mask both allow
  assign overflow_irq = st.ovf_flag && st.ctrl_one[frt_pkg::CR1_OVF_IE] && !global_irq_mask;
  assign capture_irq = (cap1_flag || cap2_flag) && st.ctrl_one[frt_pkg::CR1_CAP_IE]
                       && !global_irq_mask;
endmodule : frt_timer
`default_nettype wire

// [rtl/frt_pkg.sv]
// Package for the free-running timer with input capture
package frt_pkg;
  // Register word offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CAP1_HI = 8'h0C;
  localparam logic [7:0] OFF_CAP1_LO = 8'h10;
  localparam logic [7:0] OFF_CNT_HI = 8'h14;
  localparam logic [7:0] OFF_CNT_LO = 8'h18;
  localparam logic [7:0] OFF_ALT_HI = 8'h1C;
  localparam logic [7:0] OFF_ALT_LO = 8'h20;
  localparam logic [7:0] OFF_CAP2_HI = 8'h24;
  localparam logic [7:0] OFF_CAP2_LO = 8'h28;
  // Control one fields
  localparam int CR1_CAP_IE = 7;
  localparam int CR1_OVF_IE = 5;
  localparam int CR1_EDGE1 = 1;
  // Control two fields
  localparam int CR2_PWM = 7;
  localparam int CR2_OPM = 4;
  localparam int CR2_CLK_HI = 3;
  localparam int CR2_CLK_LO = 2;
  localparam int CR2_EDGE2 = 1;
  localparam int CR2_EXT_EDGE = 0;
  // Status fields
  localparam int SR_CAP1 = 7;
  localparam int SR_OVF = 5;
  localparam int SR_CAP2 = 4;
  // Values after reset
  localparam logic [15:0] CNT_RESET = 16'hFFFC;
  localparam logic [7:0] CR1_RESET = 8'h00;
  localparam logic [7:0] CR2_RESET = 8'h00;
  // Prescale divide ratios
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
endpackage : frt_pkg

// [rtl/frt_capture_chan.sv]
// One input capture channel: edge detect, capture register, flag and read inhibit
`timescale 1ns/10ps
`default_nettype none
module frt_capture_chan (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic pin_sync,
  input wire logic edge_rising,
  input wire logic enable,
  input wire logic [15:0] count,
  input wire logic status_read,
  input wire logic high_read,
  input wire logic low_access,
  input wire logic low_read,
  output logic [15:0] capture_register,
  output logic capture_flag,
  output logic capture_event
);
  typedef struct packed {
    logic pin_last;
    logic pin_seen;
    logic inhibit;
    logic armed;
    logic flag;
    logic [15:0] value;
  } frt_cap_state_t;

  frt_cap_state_t st;
  frt_cap_state_t next_st;
  logic active_edge;
  logic take;

  always_comb begin
    next_st = st;
    next_st.pin_last = pin_sync;
    next_st.pin_seen = 1'b1;
    active_edge = st.pin_seen && (edge_rising ? (pin_sync && !st.pin_last)
                                              : (!pin_sync && st.pin_last));
    // Pins are watched whatever their port direction; only inhibit and a low enable block
    take = active_edge && enable && !st.inhibit;
    if (high_read) begin
      next_st.inhibit = 1'b1;
    end
    if (low_read) begin
      next_st.inhibit = 1'b0;
    end
    if (status_read && st.flag) begin
      next_st.armed = 1'b1;
    end
    if (low_access && st.armed) begin
      next_st.flag = 1'b0;
      next_st.armed = 1'b0;
    end
    // A new capture beats a clear in the same cycle
    if (take) begin
      next_st.value = count;
      next_st.flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign capture_register = st.value;
  assign capture_flag = st.flag;
  assign capture_event = take;
endmodule : frt_capture_chan
`default_nettype wire

// [bench/frt_pin_src.sv]
// Far-side pin sources: external timer clock and capture pin levels
`timescale 1ns/10ps
`default_nettype none
module frt_pin_src (
  input wire logic pclk,
  input wire logic ext_run,
  input wire logic [1:0] cap_lvl,
  output logic ext_clock_pin,
  output logic capture_pin_one,
  output logic capture_pin_two
);
  logic [1:0] div;
  initial begin
    div = 2'h0;
    ext_clock_pin = 1'b0;
  end
  // Toggle every 4 cycles, so edges of one kind stay 8 pclk apart
  always @(posedge pclk) begin
    div <= ext_run ? div + 2'h1 : 2'h0;
    if (ext_run && div == 2'h3) begin
      ext_clock_pin <= !ext_clock_pin;
    end
  end
  assign capture_pin_one = cap_lvl[0];
  assign capture_pin_two = cap_lvl[1];
endmodule : frt_pin_src
`default_nettype wire

// [bench/frt_timer_checker.sv]
// Port assertions for the free-running timer
`timescale 1ns/10ps
`default_nettype none
module frt_timer_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_mask,
  input wire logic overflow_irq,
  input wire logic capture_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire ovf_src = acc && (paddr == frt_pkg::OFF_CNT_LO || paddr == frt_pkg::OFF_CTRL_ONE);
  wire cap_src = acc && (paddr == frt_pkg::OFF_CAP1_LO || paddr == frt_pkg::OFF_CAP2_LO
    || paddr == frt_pkg::OFF_CTRL_ONE);
  property p_rdy; acc && !pready |-> !pwrite ##1 pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access without ready");
  property p_ovf_mask; overflow_irq |-> !global_irq_mask; endproperty
  a_ovf_mask: assert property (p_ovf_mask) else $error("overflow irq while masked");
  property p_cap_mask; capture_irq |-> !global_irq_mask; endproperty
  a_cap_mask: assert property (p_cap_mask) else $error("capture irq while masked");
  property p_ovf_clr; $fell(overflow_irq) && $stable(global_irq_mask) |-> $past(ovf_src); endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow irq dropped alone");
  property p_cap_clr; $fell(capture_irq) && $stable(global_irq_mask) |-> $past(cap_src); endproperty
  a_cap_clr: assert property (p_cap_clr) else $error("capture irq dropped alone");
  property p_bad_rd; acc && !pwrite && paddr > frt_pkg::OFF_CAP2_LO |=> prdata == 32'h0; endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not zero");
  property p_err; acc |-> pslverr == (paddr > frt_pkg::OFF_CAP2_LO); endproperty
  a_err: assert property (p_err) else $error("wrong error response");
  // Software may sample read data late, so it must stand until the next read
  property p_rd_stand; !(acc && !pwrite) |=> $stable(prdata); endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data changed");
endmodule : frt_timer_checker
`default_nettype wire

// [bench/frt_timer_tb.sv]
// Self-checking bench for the free-running timer
`timescale 1ns/10ps
`default_nettype none
module free_running_timer_capture_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic halt_mode = 1'b0, global_irq_mask = 1'b0, ext_run = 1'b0;
  logic [1:0] cap_lvl = 2'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, ext_clock_pin, capture_pin_one, capture_pin_two, overflow_irq;
  logic capture_irq, err;
  logic [15:0] c16;
  logic [7:0] ca;
  int n_errors = 0, n_checks = 0, cycles = 0, fb;
  always #25 pclk = !pclk;
  frt_timer i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
    .global_irq_mask(global_irq_mask), .ext_clock_pin(ext_clock_pin),
    .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
    .overflow_irq(overflow_irq), .capture_irq(capture_irq));
  frt_pin_src i_src (.pclk(pclk), .ext_run(ext_run), .cap_lvl(cap_lvl),
    .ext_clock_pin(ext_clock_pin), .capture_pin_one(capture_pin_one),
    .capture_pin_two(capture_pin_two));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Request held until the edge at which pready stands high; data taken just before it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    err = pslverr;
    rv = prdata;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd16(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
    c16[15:8] = rv[7:0];
    apb(1'b0, a + 8'h04, 8'h00);
    c16[7:0] = rv[7:0];
  endtask : rd16
  task automatic st(input int b, input logic v);
    apb(1'b0, frt_pkg::OFF_STATUS, 8'h00);
    chk(rv[b], v);
  endtask : st
  task automatic pin(input int i, input logic v);
    cap_lvl[i] <= v;
    repeat (8) @(posedge pclk);
  endtask : pin
  function automatic logic [15:0] exp_cnt(input int n, input int dv, input logic ext);
    return 16'hFFFC + 16'(ext ? n / 8 : (n + 9) / dv);
  endfunction : exp_cnt
  task automatic run_rate(input logic [7:0] ctl, input int dv, input logic ext);
    int n;
    logic [15:0] h;
    n = 40 + $urandom % 40;
    halt_mode <= 1'b0;
    apb(1'b1, frt_pkg::OFF_CTRL_TWO, ctl);
    apb(1'b1, frt_pkg::OFF_CNT_LO, 8'h00);
    ext_run <= ext;
    repeat (n) @(posedge pclk);
    ext_run <= 1'b0;
    repeat (8) @(posedge pclk);
    halt_mode <= 1'b1;
    rd16(frt_pkg::OFF_CNT_HI);
    h = c16 - exp_cnt(n, dv, ext);
    chk(h inside {16'h0, 16'h1, 16'hFFFF}, 1'b1);
    h = c16;
    repeat (20) @(posedge pclk);
    rd16(frt_pkg::OFF_CNT_HI);
    chk(c16, h);
  endtask : run_rate
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(33));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd16(frt_pkg::OFF_CNT_HI);
    chk(c16[15:2], 14'h3FFF);
    apb(1'b0, frt_pkg::OFF_CTRL_ONE, 8'h00);
    chk(rv[7:0], frt_pkg::CR1_RESET);
    apb(1'b0, 8'h2C, 8'h00);
    chk({err, rv}, {1'b1, 32'h0});
    run_rate(8'h00, 4, 1'b0);
    run_rate(8'h04, 2, 1'b0);
    run_rate(8'h08, 8, 1'b0);
    run_rate(8'h0C, 8, 1'b1);
    run_rate(8'h0D, 8, 1'b1);
    halt_mode <= 1'b0;
    apb(1'b1, frt_pkg::OFF_ALT_LO, 8'h00);
    rd16(frt_pkg::OFF_ALT_HI);
    chk(c16, 16'hFFFC);
    rd16(frt_pkg::OFF_CNT_HI);
    chk(c16, 16'hFFFC);
    apb(1'b0, frt_pkg::OFF_CNT_HI, 8'h00);
    ext_run <= 1'b1;
    repeat (40) @(posedge pclk);
    ext_run <= 1'b0;
    repeat (8) @(posedge pclk);
    rd16(frt_pkg::OFF_CNT_HI);
    chk(c16[7:0], 8'hFC);
    apb(1'b0, frt_pkg::OFF_CNT_LO, 8'h00);
    chk(rv[7:0] != 8'hFC, 1'b1);
    apb(1'b1, frt_pkg::OFF_CTRL_ONE, 8'h20);
    @(negedge pclk);
    chk(overflow_irq, 1'b1);
    @(posedge pclk);
    global_irq_mask <= 1'b1;
    @(negedge pclk);
    chk(overflow_irq, 1'b0);
    @(posedge pclk);
    global_irq_mask <= 1'b0;
    st(frt_pkg::SR_OVF, 1'b1);
    apb(1'b0, frt_pkg::OFF_ALT_LO, 8'h00);
    st(frt_pkg::SR_OVF, 1'b1);
    apb(1'b1, frt_pkg::OFF_CNT_LO, 8'h00);
    st(frt_pkg::SR_OVF, 1'b0);
    for (int i = 0; i < 2; i++) begin
      ca = i ? frt_pkg::OFF_CAP2_HI : frt_pkg::OFF_CAP1_HI;
      fb = i ? frt_pkg::SR_CAP2 : frt_pkg::SR_CAP1;
      apb(1'b1, frt_pkg::OFF_CTRL_ONE, i ? 8'h82 : 8'h80);
      apb(1'b1, frt_pkg::OFF_CTRL_TWO, i ? 8'h0C : 8'h0E);
      apb(1'b1, frt_pkg::OFF_CNT_LO, 8'h00);
      pin(i, 1'b1);
      st(fb, 1'b0);
      pin(i, 1'b0);
      st(fb, 1'b1);
      chk(capture_irq, 1'b1);
      rd16(ca);
      chk(c16, 16'hFFFC);
      st(fb, 1'b0);
      apb(1'b0, ca, 8'h00);
      pin(i, 1'b1);
      pin(i, 1'b0);
      st(fb, 1'b0);
      apb(1'b0, ca + 8'h04, 8'h00);
      pin(i, 1'b1);
      pin(i, 1'b0);
      st(fb, 1'b1);
      apb(1'b0, ca + 8'h04, 8'h00);
      st(fb, 1'b0);
    end
    apb(1'b1, frt_pkg::OFF_CTRL_TWO, 8'h1C);
    pin(0, 1'b1);
    st(frt_pkg::SR_CAP1, 1'b0);
    pin(1, 1'b1);
    pin(1, 1'b0);
    st(frt_pkg::SR_CAP2, 1'b1);
    report_and_stop();
  end
endmodule : free_running_timer_capture_tb
bind frt_timer frt_timer_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .global_irq_mask(global_irq_mask), .overflow_irq(overflow_irq),
  .capture_irq(capture_irq));
`default_nettype wire
